// file: hdl/mbs_brake_seq.sv
// Motor brake release sequencer top
//
// Behaviour
// (R1) Output low while operating means the brake holds the motor locked.
// (R2) Output high means brake released and motor free to rotate.
// (R3) Separate programmable on-delay and off-delay shape the output.
// (R4) Brake engages only after the servo has been switched off.
// (R5) External brake controller engages during deceleration only.
// (R6) External brake force acts in the motor braking direction.
// (R7) Servo off, speed above threshold: output drops when off-delay elapses.
// (R8) Servo off: output drops early once speed falls below threshold.
// (R9) Servo on: output rises only after the on-delay has elapsed.
`default_nettype none
`include "mbs_defines.svh"

module mbs_brake_seq #(
    parameter int P_CYC_PER_MS = `MBS_CYC_PER_MS
) (
    input  wire logic                    i_clk,
    input  wire logic                    i_rst,
    input  wire logic                    i_servo_enable_input,
    input  wire logic [`MBS_SPEED_W-1:0] i_motor_speed,
    input  wire mbs_pkg::mbs_cfg_s       i_cfg,
    output var  logic                    o_brake_release_output
);

    logic [1:0]          sync_r;
    logic [1:0]          sync_nxt;
    logic                servo_on;
    mbs_pkg::mbs_state_e state_r;
    mbs_pkg::mbs_state_e state_nxt;
    logic                brake_r;
    logic                brake_nxt;
    logic                on_run;
    logic                off_run;
    logic                on_done;
    logic                off_done;
    logic                below_thr;

    // Pin synchroniser for the servo enable
    always_comb begin
        sync_nxt = {sync_r[0], i_servo_enable_input};
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sync_r <= `MBS_RST_SYNC;
        end else begin
            sync_r <= sync_nxt;
        end
    end

    assign servo_on = sync_r[1];

    // Speed compare against zero-speed threshold
    assign below_thr = (i_motor_speed < i_cfg.zero_speed_threshold_setting);

    // Timers run only in their wait states
    assign on_run  = (state_r == mbs_pkg::ST_ON_WAIT);
    assign off_run = (state_r == mbs_pkg::ST_OFF_WAIT);

    // (R3) on-delay timer
    mbs_delay_timer #(
        .P_CYC_PER_MS (P_CYC_PER_MS)
    ) u_on_timer (
        .i_clk      (i_clk),
        .i_rst      (i_rst),
        .i_run      (on_run),
        .i_delay_ms (i_cfg.brake_on_delay_setting),
        .o_done     (on_done)
    );

    // (R3) off-delay timer
    mbs_delay_timer #(
        .P_CYC_PER_MS (P_CYC_PER_MS)
    ) u_off_timer (
        .i_clk      (i_clk),
        .i_rst      (i_rst),
        .i_run      (off_run),
        .i_delay_ms (i_cfg.brake_off_delay_setting),
        .o_done     (off_done)
    );

    // Next state and output of the sequencer
    always_comb begin
        state_nxt = state_r;
        brake_nxt = brake_r;
        case (state_r)
            mbs_pkg::ST_LOCKED: begin
                // (R1) brake holds motor
                brake_nxt = 1'h0;
                if (servo_on) begin
                    state_nxt = mbs_pkg::ST_ON_WAIT;
                end
            end
            mbs_pkg::ST_ON_WAIT: begin
                brake_nxt = 1'h0;
                if (!servo_on) begin
                    state_nxt = mbs_pkg::ST_LOCKED;
                end else if (on_done) begin
                    // (R9) release after on-delay
                    state_nxt = mbs_pkg::ST_RELEASED;
                    brake_nxt = 1'h1;
                end
            end
            mbs_pkg::ST_RELEASED: begin
                // (R2) motor free to rotate
                brake_nxt = 1'h1;
                if (!servo_on) begin
                    state_nxt = mbs_pkg::ST_OFF_WAIT;
                end
            end
            mbs_pkg::ST_OFF_WAIT: begin
                brake_nxt = 1'h1;
                if (servo_on) begin
                    // (R4) no engage while servo on
                    state_nxt = mbs_pkg::ST_RELEASED;
                end else if (off_done || below_thr) begin
                    // (R7) (R8) elapsed or slow enough
                    state_nxt = mbs_pkg::ST_LOCKED;
                    brake_nxt = 1'h0;
                end
            end
            default: begin
                state_nxt = mbs_pkg::ST_LOCKED;
                brake_nxt = 1'h0;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_r <= mbs_pkg::ST_LOCKED;
            brake_r <= `MBS_RST_BRAKE;
        end else begin
            state_r <= state_nxt;
            brake_r <= brake_nxt;
        end
    end

    assign o_brake_release_output = brake_r;

    // Named steps of the sequence
    sequence s_release_req;
        state_r == mbs_pkg::ST_LOCKED && servo_on;
    endsequence

    sequence s_servo_drop;
        state_r == mbs_pkg::ST_RELEASED && !servo_on;
    endsequence

    sequence s_off_hold;
        state_r == mbs_pkg::ST_OFF_WAIT && !servo_on && !off_done && !below_thr;
    endsequence

    property p_locked_low;
        @(posedge i_clk) disable iff (i_rst)
        (state_r == mbs_pkg::ST_LOCKED || state_r == mbs_pkg::ST_ON_WAIT) |-> !o_brake_release_output;
    endproperty
    a_locked_low: assert property (p_locked_low) else $error("Output high while brake should hold"); // R1

    property p_released_high;
        @(posedge i_clk) disable iff (i_rst)
        (state_r == mbs_pkg::ST_RELEASED) |-> o_brake_release_output;
    endproperty
    a_released_high: assert property (p_released_high) else $error("Output low while released"); // R2

    property p_rise_after_delay;
        @(posedge i_clk) disable iff (i_rst)
        $rose(o_brake_release_output) |-> $past(on_done) && $past(servo_on);
    endproperty
    a_rise_after_delay: assert property (p_rise_after_delay) else $error("Release before on-delay"); // R9

    property p_on_wait_holds;
        @(posedge i_clk) disable iff (i_rst)
        s_release_req ##1 (servo_on && !on_done) |=> !o_brake_release_output;
    endproperty
    a_on_wait_holds: assert property (p_on_wait_holds) else $error("On-delay not applied"); // R3

    property p_engage_servo_off;
        @(posedge i_clk) disable iff (i_rst)
        $fell(o_brake_release_output) |-> !$past(servo_on);
    endproperty
    a_engage_servo_off: assert property (p_engage_servo_off) else $error("Brake engaged with servo on"); // R4

    property p_off_hold;
        @(posedge i_clk) disable iff (i_rst)
        s_off_hold |=> o_brake_release_output;
    endproperty
    a_off_hold: assert property (p_off_hold) else $error("Output dropped before off-delay"); // R7

    property p_off_elapsed;
        @(posedge i_clk) disable iff (i_rst)
        (state_r == mbs_pkg::ST_OFF_WAIT && !servo_on && off_done) |=> !o_brake_release_output;
    endproperty
    a_off_elapsed: assert property (p_off_elapsed) else $error("Output kept after off-delay"); // R7

    property p_early_stop;
        @(posedge i_clk) disable iff (i_rst)
        (state_r == mbs_pkg::ST_OFF_WAIT && !servo_on && below_thr) |=> !o_brake_release_output ##1 !o_brake_release_output;
    endproperty
    a_early_stop: assert property (p_early_stop) else $error("No early engage at low speed"); // R8

    property p_servo_drop_wait;
        @(posedge i_clk) disable iff (i_rst)
        s_servo_drop |=> state_r == mbs_pkg::ST_OFF_WAIT && o_brake_release_output;
    endproperty
    a_servo_drop_wait: assert property (p_servo_drop_wait) else $error("Off-delay not entered"); // R3

    // Output held low for the whole on-delay
    property p_on_delay_hold;
        @(posedge i_clk) disable iff (i_rst)
        (state_r == mbs_pkg::ST_ON_WAIT && !on_done) |=> !o_brake_release_output;
    endproperty
    a_on_delay_hold: assert property (p_on_delay_hold) else $error("Release while on-delay running"); // R9

    // Reset always leaves the brake holding
    property p_reset_clear;
        @(posedge i_clk)
        i_rst |=> !o_brake_release_output;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("Output high after reset"); // R1

endmodule

`default_nettype wire

// file: hdl/mbs_defines.svh
// Constants for the motor brake release sequencer
`ifndef MBS_DEFINES_SVH
`define MBS_DEFINES_SVH

// Widths of settings, speed and prescaler
`define MBS_SETTING_W     16
`define MBS_SPEED_W       16
`define MBS_PRE_W         17

// Delay unit and clock period
`define MBS_DELAY_UNIT_NS 1000000
`define MBS_CLK_PERIOD_NS 10
`define MBS_CYC_PER_MS    (`MBS_DELAY_UNIT_NS / `MBS_CLK_PERIOD_NS)

// Reset values
`define MBS_RST_BRAKE     1'h0
`define MBS_RST_SYNC      2'h0

`endif

// file: hdl/mbs_delay_timer.sv
// Millisecond delay timer, cleared while not running
`default_nettype none
`include "mbs_defines.svh"

module mbs_delay_timer #(
    parameter int P_CYC_PER_MS = `MBS_CYC_PER_MS
) (
    input  wire logic                      i_clk,
    input  wire logic                      i_rst,
    input  wire logic                      i_run,
    input  wire logic [`MBS_SETTING_W-1:0] i_delay_ms,
    output var  logic                      o_done
);

    localparam logic [`MBS_PRE_W-1:0] PRE_LAST = `MBS_PRE_W'(P_CYC_PER_MS - 1);

    logic [`MBS_PRE_W-1:0]     pre_r;
    logic [`MBS_PRE_W-1:0]     pre_nxt;
    logic [`MBS_SETTING_W-1:0] ms_r;
    logic [`MBS_SETTING_W-1:0] ms_nxt;
    logic                      done_r;
    logic                      done_nxt;

    // Prescaler, saturating ms count and elapsed flag
    always_comb begin
        pre_nxt  = pre_r;
        ms_nxt   = ms_r;
        done_nxt = 1'h0;
        if (!i_run) begin
            pre_nxt = '0;
            ms_nxt  = '0;
        end else begin
            done_nxt = (ms_r >= i_delay_ms);
            if (pre_r == PRE_LAST) begin
                pre_nxt = '0;
                if (ms_r != '1) begin
                    ms_nxt = ms_r + `MBS_SETTING_W'(1);
                end
            end else begin
                pre_nxt = pre_r + `MBS_PRE_W'(1);
            end
        end
    end

    // State registers
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pre_r  <= '0;
            ms_r   <= '0;
            done_r <= 1'h0;
        end else begin
            pre_r  <= pre_nxt;
            ms_r   <= ms_nxt;
            done_r <= done_nxt;
        end
    end

    assign o_done = done_r;

endmodule

`default_nettype wire

// file: hdl/mbs_pkg.sv
// Types for the motor brake release sequencer
`default_nettype none
`include "mbs_defines.svh"

package mbs_pkg;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_LOCKED,
        ST_ON_WAIT,
        ST_RELEASED,
        ST_OFF_WAIT
    } mbs_state_e;

    // Settings that shape the brake output
    typedef struct packed {
        logic [`MBS_SETTING_W-1:0] brake_on_delay_setting;
        logic [`MBS_SETTING_W-1:0] brake_off_delay_setting;
        logic [`MBS_SPEED_W-1:0]   zero_speed_threshold_setting;
    } mbs_cfg_s;

endpackage

`default_nettype wire

// file: sim/mbs_relay_model.sv
// Relay coil and holding brake model for the sequencer bench
`default_nettype none

module mbs_relay_model (
    input  wire logic i_clk,
    input  wire logic i_coil,
    output var  logic o_brake_free
);
    timeunit 1ns;
    timeprecision 1ps;

    always_ff @(posedge i_clk) begin
        o_brake_free <= i_coil; // Brake grips whenever coil drops
    end
endmodule

`default_nettype wire

// file: sim/testbench.sv
// Self-checking bench for the motor brake release sequencer
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int P = 10;
    logic              i_clk      = 1'b0;
    logic              i_rst      = 1'b1;
    logic              servo      = 1'b0;
    logic [15:0]       speed      = 16'h0000;
    mbs_pkg::mbs_cfg_s cfg        = '0;
    logic              brk;
    logic              free;
    int                mismatches = 0;
    int                checked    = 0;
    int                n;

    // Clock at 100 MHz
    always #5 i_clk = ~i_clk;

    mbs_brake_seq #(.P_CYC_PER_MS(P)) uut (
        .i_clk                  (i_clk),
        .i_rst                  (i_rst),
        .i_servo_enable_input   (servo),
        .i_motor_speed          (speed),
        .i_cfg                  (cfg),
        .o_brake_release_output (brk)
    );

    mbs_relay_model coil (
        .i_clk        (i_clk),
        .i_coil       (brk),
        .o_brake_free (free)
    );

    // Comparisons and waits
    task automatic check_bit(input string name, input logic exp, input logic got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %0b seen %0b", name, exp, got);
        end
    endtask

    task automatic check_range(input string name, input int lo, input int hi, input int got);
        checked++;
        if (got < lo || got > hi) begin
            mismatches++;
            $display("[FAIL] %s expected %0d..%0d seen %0d", name, lo, hi, got);
        end
    endtask

    task automatic step(input int c);
        repeat (c) @(posedge i_clk);
        #1;
    endtask

    task automatic wait_level(input logic lvl, input int lim);
        n = 0;
        while (brk !== lvl && n < lim) begin
            step(1);
            n++;
        end
    endtask

    task automatic hold(input logic lvl, input int c, input string name);
        logic ok;
        ok = 1'b1;
        repeat (c) begin
            step(1);
            if (brk !== lvl) ok = 1'b0;
        end
        check_bit(name, 1'b1, ok);
    endtask

    // Scenarios
    task automatic t_on(input int d);
        cfg.brake_on_delay_setting = d[15:0];
        servo = 1'b1;
        wait_level(1'b1, d * P + 20);
        check_range("on delay cycles", d * P + 2, d * P + 8, n);
        step(1);
        check_bit("brake free", 1'b1, free);
        $display("test on delay %0d done", d);
    endtask

    task automatic t_off_slow(input int d);
        cfg.brake_off_delay_setting = d[15:0];
        speed = cfg.zero_speed_threshold_setting;
        servo = 1'b0;
        wait_level(1'b0, d * P + 20);
        check_range("off delay cycles", d * P + 2, d * P + 8, n);
        step(1);
        check_bit("brake holding", 1'b0, free);
        $display("test off at threshold done");
    endtask

    task automatic t_off_early();
        cfg.brake_off_delay_setting = 16'h0032;
        speed = cfg.zero_speed_threshold_setting + 16'h000a;
        servo = 1'b0;
        hold(1'b1, 100, "released while fast");
        speed = cfg.zero_speed_threshold_setting - 16'h0001;
        wait_level(1'b0, 10);
        check_range("early engage cycles", 1, 4, n);
        $display("test early engage done");
    endtask

    task automatic t_abort_on();
        cfg.brake_on_delay_setting = 16'h0005;
        servo = 1'b1;
        step(20);
        servo = 1'b0;
        hold(1'b0, 80, "aborted release");
        $display("test aborted release done");
    endtask

    task automatic t_reset_mid(input int d);
        i_rst = 1'b1;
        step(1);
        check_bit("reset drops release", 1'b0, brk);
        step(2);
        i_rst = 1'b0;
        wait_level(1'b1, d * P + 20);
        check_range("on delay after reset", d * P + 2, d * P + 8, n);
        $display("test mid-run reset done");
    endtask

    task automatic t_return_off();
        cfg.brake_off_delay_setting = 16'h0005;
        speed = cfg.zero_speed_threshold_setting + 16'h000a;
        servo = 1'b0;
        step(20);
        servo = 1'b1;
        hold(1'b1, 100, "servo return");
        $display("test servo return done");
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        cfg.zero_speed_threshold_setting = 16'h0100;
        step(4);
        i_rst = 1'b0;
        check_bit("reset output", 1'b0, brk);
        step(3);
        t_on(0);
        t_off_slow(5);
        t_on(3);
        t_off_early();
        t_abort_on();
        t_on(2);
        t_reset_mid(2);
        t_return_off();
        give_verdict();
    end

    // Watchdog
    initial begin
        #100000;
        mismatches++;
        give_verdict();
    end
endmodule

`default_nettype wire
